// *** rtl/rxcf_regs.sv ***
// Summary of operation
// - 32-bit scratch register, read/write, no effect, resets to zero.
// - Three read-only words return identifier string, four characters each.
// - Count frames longer than 16-bit limit in 64-bit counter; limit 9600.
// - Oversize frame raises error bit 3, excluded from good octets count.
// - Forwarding bit, reset 0: 0 strips FCS, 1 passes it to client.
// - FCS always checked and mismatches flagged, stripped or forwarded.
// - Length check enable, reset 1, raises error bit 4 on length mismatch.
// - Fault status register at 0x508 exists only with fault generation.
//
// Chosen here: the APB register port.
module rxcf_regs import rxcf_pkg::*; #(
   parameter bit STATS_EN = 1'b1,
   parameter bit FAULT_EN = 1'b0,
   parameter logic [31:0] REVISION = REVISION_DEF,
   parameter logic [31:0] IDENT0 = IDENT0_DEF,
   parameter logic [31:0] IDENT1 = IDENT1_DEF,
   parameter logic [31:0] IDENT2 = IDENT2_DEF
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire rxcf_frame_s I_FRAME,
   input wire logic [1:0] I_FAULT_STATUS,
   output rxcf_result_s O_RESULT,
   output logic O_IRQ
);
   logic [31:0] scratch_reg;
   logic [15:0] size_limit_reg;
   logic fcs_fwd_reg;
   logic len_check_reg;
   logic [IRQ_W-1:0] irq_status_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [63:0] ovs_cnt_reg;
   logic [63:0] good_oct_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   rxcf_result_s result_reg;
   logic irq_reg;

   logic setup;
   logic [11:0] idx;
   logic aligned;
   logic wr;
   logic mapped;
   logic [31:0] rd_next;
   logic [31:0] wmask;
   logic oversize;
   logic is_length;
   logic [15:0] payload;
   logic len_bad;
   logic [ERR_W-1:0] err_next;
   logic [IRQ_W-1:0] ev;

   // No wait state: answer in the access phase's first cycle
   assign setup = I_PSEL && !I_PENABLE;
   assign idx = I_PADDR[ADDR_W-1:2];
   assign aligned = (I_PADDR[1:0] == 2'h0);
   assign wr = setup && I_PWRITE && aligned;

   generate
      for (genvar b = 0; b < 4; b++) begin : g_strb
         assign wmask[8*b +: 8] = {8{I_PSTRB[b]}};
      end
   endgenerate

   always_comb begin
      rd_next = 32'h0000_0000;
      mapped = aligned;
      unique case (idx)
         IDX_REVISION: rd_next = REVISION;
         IDX_SCRATCH: rd_next = scratch_reg;
         IDX_IDENT0: rd_next = IDENT0;
         IDX_IDENT1: rd_next = IDENT1;
         IDX_IDENT2: rd_next = IDENT2;
         IDX_SIZE_LIMIT: rd_next = {16'h0000, size_limit_reg};
         IDX_FCS_FWD: rd_next = {31'h0, fcs_fwd_reg};
         IDX_FAULT_STAT: begin
            mapped = aligned && FAULT_EN;
            rd_next = FAULT_EN ? {30'h0, I_FAULT_STATUS} : 32'h0;
         end
         IDX_LEN_CHECK: rd_next = {31'h0, len_check_reg};
         IDX_IRQ_STATUS: rd_next = {29'h0, irq_status_reg};
         IDX_IRQ_MASK: rd_next = {29'h0, irq_mask_reg};
         IDX_OVS_CNT_LO: rd_next = ovs_cnt_reg[31:0];
         IDX_OVS_CNT_HI: rd_next = ovs_cnt_reg[63:32];
         IDX_GOOD_OCT_LO: rd_next = good_oct_reg[31:0];
         IDX_GOOD_OCT_HI: rd_next = good_oct_reg[63:32];
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup && !mapped;
         if (setup && !I_PWRITE && mapped) begin
            prdata_reg <= rd_next;
         end else if (setup) begin
            prdata_reg <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         scratch_reg <= SCRATCH_RST;
         size_limit_reg <= SIZE_LIMIT_RST;
         fcs_fwd_reg <= FCS_FWD_RST;
         len_check_reg <= LEN_CHECK_RST;
         irq_mask_reg <= '0;
      end else if (wr) begin
         unique case (idx)
            IDX_SCRATCH:
               scratch_reg <= (scratch_reg & ~wmask) |
                  (I_PWDATA & wmask);
            IDX_SIZE_LIMIT:
               size_limit_reg <= (size_limit_reg & ~wmask[15:0]) |
                  (I_PWDATA[15:0] & wmask[15:0]);
            IDX_FCS_FWD:
               if (I_PSTRB[0]) begin
                  fcs_fwd_reg <= I_PWDATA[0];
               end
            IDX_LEN_CHECK:
               if (I_PSTRB[0]) begin
                  len_check_reg <= I_PWDATA[0];
               end
            IDX_IRQ_MASK:
               if (I_PSTRB[0]) begin
                  irq_mask_reg <= I_PWDATA[IRQ_W-1:0];
               end
            default: ;
         endcase
      end
   end

   // Frame checks
   assign oversize = I_FRAME.frame_len > size_limit_reg;
   assign is_length = I_FRAME.len_type < ETYPE_MIN;
   assign payload = I_FRAME.frame_len - HDR_BYTES - FCS_BYTES;
   // Short frames carry padding, so a length below 46 must match a 46-byte payload
   assign len_bad = len_check_reg && is_length &&
      ((I_FRAME.len_type < MIN_PAYLOAD) ?
         (payload != MIN_PAYLOAD) : (payload != I_FRAME.len_type));

   always_comb begin
      err_next = '0;
      err_next[ERR_OVERSIZE_BIT] = oversize;
      err_next[ERR_FCS_BIT] = !I_FRAME.fcs_ok;
      err_next[ERR_LENGTH_BIT] = len_bad;
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         result_reg <= '0;
      end else begin
         result_reg.valid <= I_FRAME.valid;
         result_reg.strip_fcs <= !fcs_fwd_reg;
         result_reg.error <= I_FRAME.valid ? err_next : '0;
      end
   end

   // Statistics
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         ovs_cnt_reg <= '0;
         good_oct_reg <= '0;
      end else if (STATS_EN && I_FRAME.valid) begin
         if (oversize) begin
            ovs_cnt_reg <= ovs_cnt_reg + 64'h1;
         end
         if (err_next == '0) begin
            good_oct_reg <= good_oct_reg + {48'h0, I_FRAME.frame_len};
         end
      end
   end

   // Interrupts: set wins over write-one-to-clear
   always_comb begin
      ev = '0;
      ev[IRQ_OVERSIZE] = I_FRAME.valid && oversize;
      ev[IRQ_FCS] = I_FRAME.valid && !I_FRAME.fcs_ok;
      ev[IRQ_LENGTH] = I_FRAME.valid && len_bad;
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         irq_status_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         if (wr && idx == IDX_IRQ_STATUS && I_PSTRB[0]) begin
            irq_status_reg <= (irq_status_reg & ~I_PWDATA[IRQ_W-1:0]) | ev;
         end else begin
            irq_status_reg <= irq_status_reg | ev;
         end
         irq_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end

   assign O_PRDATA = prdata_reg;
   assign O_PREADY = pready_reg;
   assign O_PSLVERR = pslverr_reg;
   assign O_RESULT = result_reg;
   assign O_IRQ = irq_reg;
endmodule

// *** rtl/rxcf_pkg.sv ***
package rxcf_pkg;
   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_REVISION = 12'h500;
   localparam logic [11:0] IDX_SCRATCH = 12'h501;
   localparam logic [11:0] IDX_IDENT0 = 12'h502;
   localparam logic [11:0] IDX_IDENT1 = 12'h503;
   localparam logic [11:0] IDX_IDENT2 = 12'h504;
   localparam logic [11:0] IDX_SIZE_LIMIT = 12'h506;
   localparam logic [11:0] IDX_FCS_FWD = 12'h507;
   localparam logic [11:0] IDX_FAULT_STAT = 12'h508;
   localparam logic [11:0] IDX_LEN_CHECK = 12'h50A;
   localparam logic [11:0] IDX_IRQ_STATUS = 12'h510;
   localparam logic [11:0] IDX_IRQ_MASK = 12'h511;
   localparam logic [11:0] IDX_OVS_CNT_LO = 12'h512;
   localparam logic [11:0] IDX_OVS_CNT_HI = 12'h513;
   localparam logic [11:0] IDX_GOOD_OCT_LO = 12'h514;
   localparam logic [11:0] IDX_GOOD_OCT_HI = 12'h515;
   localparam int ADDR_W = 14;

   localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
   localparam logic [15:0] SIZE_LIMIT_RST = 16'h2580;
   localparam logic FCS_FWD_RST = 1'b0;
   localparam logic LEN_CHECK_RST = 1'b1;
   // Arbitrary neutral identity values
   localparam logic [31:0] REVISION_DEF = 32'h0001_0000;
   localparam logic [31:0] IDENT0_DEF = 32'h7278_6366;
   localparam logic [31:0] IDENT1_DEF = 32'h6752_6567;
   localparam logic [31:0] IDENT2_DEF = 32'h7320_2020;

   // Error flag bit positions
   localparam int ERR_FCS_BIT = 1;
   localparam int ERR_OVERSIZE_BIT = 3;
   localparam int ERR_LENGTH_BIT = 4;
   localparam int ERR_W = 5;
   // Interrupt status bit positions
   localparam int IRQ_OVERSIZE = 0;
   localparam int IRQ_FCS = 1;
   localparam int IRQ_LENGTH = 2;
   localparam int IRQ_W = 3;

   localparam logic [15:0] ETYPE_MIN = 16'h0600;
   localparam logic [15:0] FCS_BYTES = 16'h0004;
   localparam logic [15:0] HDR_BYTES = 16'h000E;
   localparam logic [15:0] MIN_PAYLOAD = 16'h002E;

   typedef struct packed {
      logic valid;
      logic [15:0] frame_len;
      logic [15:0] len_type;
      logic fcs_ok;
   } rxcf_frame_s;

   typedef struct packed {
      logic valid;
      logic strip_fcs;
      logic [ERR_W-1:0] error;
   } rxcf_result_s;
endpackage

// *** testbench/rxcf_regs_assertions.sv ***
module rxcf_regs_assertions import rxcf_pkg::*; (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic [ADDR_W-1:0] I_PADDR,
   input wire rxcf_frame_s I_FRAME,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   input wire rxcf_result_s O_RESULT
);
   default clocking @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);
   property p_rdy; I_PSEL && !I_PENABLE |=> O_PREADY; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_one; O_PREADY |=> !O_PREADY; endproperty
   a_one: assert property (p_one) else $error("long ready");
   property p_gap; I_PSEL && !I_PENABLE && I_PADDR == 14'h1420
      |=> O_PSLVERR && O_PREADY; endproperty
   a_gap: assert property (p_gap) else $error("fault reg seen");
   property p_res; I_FRAME.valid |=> O_RESULT.valid; endproperty
   a_res: assert property (p_res) else $error("no result");
   property p_idle; !I_FRAME.valid |=> !O_RESULT.valid; endproperty
   a_idle: assert property (p_idle) else $error("stray result");
   property p_fcs; I_FRAME.valid
      |=> O_RESULT.error[1] == !$past(I_FRAME.fcs_ok); endproperty
   a_fcs: assert property (p_fcs) else $error("fcs flag");
   property p_typ; I_FRAME.valid && I_FRAME.len_type >= 16'h0600
      |=> !O_RESULT.error[4]; endproperty
   a_typ: assert property (p_typ) else $error("type flagged");
   property p_strip; $changed(O_RESULT.strip_fcs)
      |-> $past(O_PREADY) || $past(I_RST) || $past(I_RST, 2); endproperty
   a_strip: assert property (p_strip) else $error("strip moved");
endmodule
bind rxcf_regs rxcf_regs_assertions u_rxcf_regs_assertions (
   .I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
   .I_PADDR(I_PADDR), .I_FRAME(I_FRAME), .O_PREADY(O_PREADY),
   .O_PSLVERR(O_PSLVERR), .O_RESULT(O_RESULT));

// *** testbench/rxcf_client_model.sv ***
module rxcf_client_model import rxcf_pkg::*; (
   input wire logic i_clk,
   input wire rxcf_result_s i_result,
   output logic [7:0] o_count
);
   timeunit 1ns;
   timeprecision 1ns;
   initial o_count = 8'h00;
   // Client tally of delivered frame results
   always @(posedge i_clk) begin
      if (i_result.valid === 1'b1) begin
         o_count <= o_count + 8'h01;
      end
   end
endmodule

// *** testbench/tb_rxcf_regs.sv ***
module tb_rxcf_regs;
   import rxcf_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, irq, rdy, serr;
   logic [13:0] paddr = '0;
   logic [31:0] pwd = '0, prd, r;
   rxcf_frame_s frame = '0;
   rxcf_result_s res;
   logic [7:0] cnt;
   logic e;
   int miscompares = 0, compares = 0, cyc = 0;
   always #20 clk = ~clk;
   rxcf_regs u_rxcf_regs (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd),
      .I_PSTRB(4'hF), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(serr),
      .I_FRAME(frame), .I_FAULT_STATUS(2'b00), .O_RESULT(res), .O_IRQ(irq));
   rxcf_client_model u_rxcf_client_model (.i_clk(clk), .i_result(res),
      .o_count(cnt));
   task automatic wrap_up;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] idx,
         input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {idx, 2'b00};
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      r = prd;
      e = serr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(exp, r);
   endtask
   task automatic frm(input logic [15:0] len, input logic [15:0] lt,
         input logic ok, input logic [4:0] exp);
      @(posedge clk);
      frame <= '{1'b1, len, lt, ok};
      @(posedge clk);
      frame.valid <= 1'b0;
      #1 chk({26'h0, 1'b1, exp}, {26'h0, res.valid, res.error});
   endtask
   task automatic t_regs;
      rdchk(IDX_SCRATCH, 32'h0);
      rdchk(IDX_SIZE_LIMIT, 32'h2580);
      rdchk(IDX_FCS_FWD, 32'h0);
      rdchk(IDX_LEN_CHECK, 32'h1);
      apb(1'b1, IDX_SCRATCH, 32'hA5C3_0F1E);
      rdchk(IDX_SCRATCH, 32'hA5C3_0F1E);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, IDX_IDENT0 + 12'(i), 32'hFFFF_FFFF);
      end
      rdchk(IDX_IDENT0, IDENT0_DEF);
      rdchk(IDX_IDENT1, IDENT1_DEF);
      rdchk(IDX_IDENT2, IDENT2_DEF);
      rdchk(IDX_REVISION, REVISION_DEF);
      rdchk(IDX_FAULT_STAT, 32'h0);
      chk(32'h1, {31'h0, e});
   endtask
   task automatic t_len;
      frm(16'h0076, 16'h0064, 1'b1, 5'h00);
      frm(16'h0078, 16'h0064, 1'b1, 5'h10);
      frm(16'h0078, 16'h0800, 1'b1, 5'h00);
      apb(1'b1, IDX_LEN_CHECK, 32'h0);
      frm(16'h0078, 16'h0064, 1'b1, 5'h00);
   endtask
   task automatic t_fcs;
      chk(32'h1, {31'h0, res.strip_fcs});
      frm(16'h0040, 16'h0800, 1'b0, 5'h02);
      apb(1'b1, IDX_FCS_FWD, 32'h1);
      #1 chk(32'h0, {31'h0, res.strip_fcs});
      frm(16'h0040, 16'h0800, 1'b0, 5'h02);
   endtask
   task automatic t_size;
      frm(16'h2581, 16'h0800, 1'b1, 5'h08);
      frm(16'h2580, 16'h0800, 1'b1, 5'h00);
      apb(1'b1, IDX_SIZE_LIMIT, 32'h0064);
      frm(16'h0065, 16'h0800, 1'b1, 5'h08);
      rdchk(IDX_OVS_CNT_LO, 32'h2);
      rdchk(IDX_GOOD_OCT_LO, 32'h26E6);
   endtask
   task automatic t_irq;
      chk(32'h0, {31'h0, irq});
      apb(1'b1, IDX_IRQ_MASK, 32'h7);
      rdchk(IDX_IRQ_STATUS, 32'h7);
      chk(32'h1, {31'h0, irq});
      apb(1'b1, IDX_IRQ_STATUS, 32'h5);
      rdchk(IDX_IRQ_STATUS, 32'h2);
      apb(1'b1, IDX_IRQ_STATUS, 32'h2);
      @(posedge clk);
      #1 chk(32'h0, {31'h0, irq});
      frm(16'h0040, 16'h0800, 1'b0, 5'h02);
      @(posedge clk);
      #1 chk(32'h1, {31'h0, irq});
      chk(32'hA, {24'h0, cnt});
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_len();
      t_fcs();
      t_size();
      t_irq();
      wrap_up();
   end
endmodule
